/* adbc_top.sv */
// The APB interface to the registers and the register addresses were decided locally.
`default_nettype none

module adbc_top import adbc_pkg::*; #(
  parameter int DATA_W   = 14,            // 14 or 12 bit words
  parameter int GPD_WAKE = GPD_WAKE_CYC   // full power down wake, shorten in sim
) (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // converter core and pins
  input  wire logic              SAMPLE_CLK,
  input  wire logic [13:0]       RAW_DATA,
  input  wire logic              OVR_POS,
  input  wire logic              OVR_NEG,
  input  wire logic              PAR_CFG_MODE,
  input  wire logic              SERIAL_DATA_PIN,
  input  wire logic              FORMAT_STRAP_PIN,
  // power control toward the analog side
  output logic                   CONV_PD,
  output logic                   REF_PD,
  output logic                   LOW_POWER,
  // output pins
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   OUTPUT_CLOCK_POS,
  output logic                   OUT_EN_N,
  output logic                   DATA_VALID
);
  // =====================================================================
  // pin synchronisers
  localparam int SW = 20;
  logic [SW-1:0] pin_s1_q;   // first stage, read only by the second
  logic [SW-1:0] pin_s2_q;   // safe copy of all pins

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {SAMPLE_CLK, OVR_POS, OVR_NEG, PAR_CFG_MODE, SERIAL_DATA_PIN,
                   FORMAT_STRAP_PIN, RAW_DATA};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic        sclk_s;     // sample clock level
  logic        ovr_pos_s;  // positive overdrive
  logic        ovr_neg_s;  // negative overdrive
  logic        par_s;      // parallel configuration mode
  logic        serial_data_pin_s;    // serial data pin
  logic        strap_s;    // format strap pin
  logic [13:0] raw_s;      // core sample, twos complement
  assign {sclk_s, ovr_pos_s, ovr_neg_s, par_s, serial_data_pin_s, strap_s, raw_s} = pin_s2_q;

  // edge finder on the sampled link clock
  logic sclk_prev_q;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  logic rise_stb;   // one cycle per sample
  logic fall_stb;
  assign rise_stb = sclk_s & ~sclk_prev_q;
  assign fall_stb = ~sclk_s & sclk_prev_q;

  // =====================================================================
  // apb register file
  adbc_ctrl_s ctrl_q;       // control word
  logic       lock_q;       // estimate frozen
  logic       wr_ctrl;      // access-phase write to the control word
  logic       hit;          // address maps to a register
  adbc_ctrl_s wr_val;       // incoming control image
  assign hit     = (PADDR == CTRL_OFS) || (PADDR == STAT_OFS);
  assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == CTRL_OFS);
  assign wr_val  = adbc_ctrl_s'(PWDATA[16:0]);
  // zero wait states: every access finishes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // control word; illegal codes leave the old setting in place
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q      <= '0;
      ctrl_q.gain <= GAIN_RST;
      ctrl_q.tc   <= TC_RST;
    end else if (wr_ctrl) begin
      ctrl_q.ofs_en           <= wr_val.ofs_en;
      ctrl_q.full_power_down  <= wr_val.full_power_down;
      ctrl_q.standby          <= wr_val.standby;
      ctrl_q.output_drive_off <= wr_val.output_drive_off;
      ctrl_q.output_style_sel <= wr_val.output_style_sel;
      ctrl_q.twos             <= wr_val.twos;
      if (wr_val.gain <= GAIN_MAX_CODE) begin
        ctrl_q.gain <= wr_val.gain;
      end
      if (wr_val.tc <= TC_MAX_CODE) begin
        ctrl_q.tc <= wr_val.tc;
      end
    end
  end

  // lock: a zero time constant written after the loop has run freezes it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (!wr_val.ofs_en) begin
        lock_q <= 1'b0;
      end else if (wr_val.tc == 4'h0 && ctrl_q.ofs_en && ctrl_q.tc != 4'h0) begin
        lock_q <= 1'b1;
      end else if (wr_val.tc != 4'h0 && wr_val.tc <= TC_MAX_CODE) begin
        lock_q <= 1'b0;
      end
    end
  end

  // read data is latched in the setup cycle, stable through the access
  logic [15:0] est_c;       // clamped estimate
  logic        lowpwr_q;
  logic        hiz;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= '0;
      if (PADDR == CTRL_OFS) begin
        PRDATA[16:0] <= ctrl_q;
      end else if (PADDR == STAT_OFS) begin
        PRDATA[ST_LOCK_BIT]           <= lock_q;
        PRDATA[ST_LOWPWR_BIT]         <= lowpwr_q;
        PRDATA[ST_VALID_BIT]          <= DATA_VALID;
        PRDATA[ST_HIZ_BIT]            <= hiz;
        PRDATA[ST_EST_LSB +: 16]      <= est_c;
      end
    end
  end

  // =====================================================================
  // power control
  logic        gpd;        // full power down request
  logic        stby;       // standby request
  logic [12:0] wake_q;     // converter wake countdown
  logic [3:0]  obuf_q;     // output restore countdown
  assign gpd  = par_s ? serial_data_pin_s : ctrl_q.full_power_down;
  assign stby = ctrl_q.standby && !gpd;

  // full down reloads the long wake; standby only holds the short one
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_q <= '0;
    end else if (gpd) begin
      wake_q <= 13'(GPD_WAKE);
    end else if (stby) begin
      wake_q <= (wake_q > 13'(STBY_WAKE_CYC)) ? wake_q : 13'(STBY_WAKE_CYC);
    end else if (wake_q != '0) begin
      wake_q <= wake_q - 13'd1;
    end
  end

  // buffers come back a short while after both float requests clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      obuf_q <= '0;
    end else if (gpd || ctrl_q.output_drive_off) begin
      obuf_q <= 4'(OBUF_WAKE_CYC);
    end else if (obuf_q != '0) begin
      obuf_q <= obuf_q - 4'd1;
    end
  end

  assign hiz        = gpd || (obuf_q != '0);
  assign OUT_EN_N   = hiz;
  assign CONV_PD    = gpd || stby;
  assign REF_PD     = gpd;
  assign DATA_VALID = !gpd && !stby && (wake_q == '0);

  // slow clock watch: no rising edge for a microsecond means low power
  logic [7:0] idle_q;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      idle_q   <= '0;
      lowpwr_q <= 1'b0;
    end else begin
      if (rise_stb) begin
        idle_q   <= '0;
        lowpwr_q <= 1'b0;
      end else if (idle_q < 8'(LOWPWR_CYC)) begin
        idle_q <= idle_q + 8'd1;
      end else begin
        lowpwr_q <= 1'b1;
      end
    end
  end
  assign LOW_POWER = lowpwr_q;

  // =====================================================================
  // offset loop: leaky integrator, acc holds estimate scaled by 2^k
  logic signed [45:0] acc_q;
  logic        [4:0]  shift;     // 18 .. 29
  logic signed [45:0] est_full;  // acc >>> k
  logic signed [15:0] x_s;       // core sample widened
  assign shift    = 5'(TC_BASE_LOG2) + {1'b0, ctrl_q.tc};
  assign est_full = acc_q >>> shift;
  assign x_s      = 16'(signed'(raw_s));

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= '0;
    end else if (!ctrl_q.ofs_en) begin
      acc_q <= '0;
    end else if (rise_stb && !lock_q) begin
      acc_q <= acc_q + 46'(x_s) - est_full;
    end
  end

  // correction never exceeds the cancellable range
  always_comb begin
    if (est_full > 46'(OFS_LIMIT_LSB)) begin
      est_c = 16'(OFS_LIMIT_LSB);
    end else if (est_full < -46'(OFS_LIMIT_LSB)) begin
      est_c = 16'(-OFS_LIMIT_LSB);
    end else begin
      est_c = est_full[15:0];
    end
  end

  // =====================================================================
  // datapath: correct, scale, saturate, format
  logic signed [15:0] corr_v;   // corrected sample
  logic signed [31:0] prod;     // gain product, q12
  logic signed [31:0] scaled;
  logic        [13:0] sat;      // saturated twos complement
  logic        [13:0] word14;   // final 14-bit code
  logic               twos_sel;
  logic               par_sel;
  assign corr_v   = ctrl_q.ofs_en ? (x_s - signed'(est_c)) : x_s;
  assign prod     = 32'(corr_v) * signed'({17'h00000, GAIN_Q12[ctrl_q.gain]});
  assign scaled   = prod >>> 12;
  assign twos_sel = par_s ? strap_s : ctrl_q.twos;
  assign par_sel  = par_s ? strap_s : ctrl_q.output_style_sel;

  always_comb begin
    if (scaled > 32'sd8191) begin
      sat = 14'h1FFF;
    end else if (scaled < -32'sd8192) begin
      sat = 14'h2000;
    end else begin
      sat = scaled[13:0];
    end
    if (ovr_pos_s) begin
      word14 = twos_sel ? TC_POS_CODE : OB_POS_CODE;
    end else if (ovr_neg_s) begin
      word14 = twos_sel ? TC_NEG_CODE : OB_NEG_CODE;
    end else begin
      word14 = twos_sel ? sat : (sat ^ OB_FLIP);
    end
  end

  // only a running converter produces new words
  logic run_rise;
  logic run_fall;
  assign run_rise = rise_stb && DATA_VALID;
  assign run_fall = fall_stb && DATA_VALID;

  // narrower parts keep the top bits of the word
  adbc_ddr_out #(
    .DATA_W   (DATA_W)
  ) u_out (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .rise_stb (run_rise),
    .fall_stb (run_fall),
    .word     (word14[13 -: DATA_W]),
    .par_mode (par_sel),
    .out_data (DATA_OUT),
    .out_clk  (OUTPUT_CLOCK_POS)
  );

  // =====================================================================
  // checks
  logic wr_seen_q;   // a control write has happened since reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_seen_q <= 1'b0;
    end else if (wr_ctrl) begin
      wr_seen_q <= 1'b1;
    end
  end

  sequence s_gpd_release;
    gpd ##1 !gpd;
  endsequence

  // the restore count is last loaded one edge before the edge that sees the request drop
  sequence s_obuf_hold;
    OUT_EN_N [*8] ##1 !OUT_EN_N;
  endsequence

  a_gain_reset_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    !wr_seen_q |-> (ctrl_q.gain == 4'h0 && !ctrl_q.ofs_en))
    else $error("gain or offset loop not at reset value");
  a_gain_code_legal: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_ctrl && wr_val.gain > GAIN_MAX_CODE) |=> $stable(ctrl_q.gain))
    else $error("illegal gain code accepted");
  a_tc_reserved_kept: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_ctrl && wr_val.tc > TC_MAX_CODE) |=> (ctrl_q.tc == $past(ctrl_q.tc)))
    else $error("reserved time constant accepted");
  a_lock_freezes_est: assert property (@(posedge MCLK) disable iff (!RST_N)
    (lock_q && ctrl_q.ofs_en && !wr_ctrl) |=> $stable(acc_q))
    else $error("estimate moved while locked");
  a_ofs_within_range: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($signed(est_c) <= 16'(OFS_LIMIT_LSB) && $signed(est_c) >= -16'(OFS_LIMIT_LSB)))
    else $error("offset correction beyond limit");
  a_gpd_floats_pins: assert property (@(posedge MCLK) disable iff (!RST_N)
    gpd |-> (OUT_EN_N && CONV_PD && REF_PD && !DATA_VALID))
    else $error("full power down left something on");
  a_gpd_wake_time: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_gpd_release |-> (wake_q == 13'(GPD_WAKE)))
    else $error("wake countdown not started from full value");
  a_stby_refs_on: assert property (@(posedge MCLK) disable iff (!RST_N)
    (stby && !gpd) |-> (CONV_PD && !REF_PD) ##1 (wake_q >= 13'(STBY_WAKE_CYC)))
    else $error("standby touched the reference");
  a_obuf_restore: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($fell(ctrl_q.output_drive_off) && !gpd) |-> s_obuf_hold)
    else $error("buffers restored at wrong time");
  a_lowpwr_entry: assert property (@(posedge MCLK) disable iff (!RST_N)
    (idle_q == 8'(LOWPWR_CYC) && !rise_stb) |=> lowpwr_q)
    else $error("low power not entered on slow clock");
  a_ovr_clamp: assert property (@(posedge MCLK) disable iff (!RST_N)
    ovr_pos_s |-> (word14 == (twos_sel ? 14'h1FFF : 14'h3FFF)))
    else $error("positive overdrive not clamped");
endmodule

`default_nettype wire

/* adbc_pkg.sv */
`default_nettype none

// =====================================================================
// shared constants and types
package adbc_pkg;
  // register map, byte addresses on the apb bus
  localparam logic [11:0] CTRL_OFS        = 12'h000;   // control word
  localparam logic [11:0] STAT_OFS        = 12'h004;   // status word
  // control field positions
  localparam int          GAIN_LSB        = 0;         // 4-bit half-db gain code
  localparam int          OFS_EN_BIT      = 4;         // offset loop enable
  localparam int          TC_LSB          = 8;         // 4-bit time constant code
  localparam int          FULL_PD_BIT     = 12;        // full_power_down
  localparam int          STANDBY_BIT     = 13;        // converter standby
  localparam int          DRIVE_OFF_BIT   = 14;        // output_drive_off
  localparam int          STYLE_BIT       = 15;        // output_style_sel, 1 = parallel
  localparam int          TWOS_BIT        = 16;        // 1 = twos complement
  // status field positions
  localparam int          ST_LOCK_BIT     = 0;
  localparam int          ST_LOWPWR_BIT   = 1;
  localparam int          ST_VALID_BIT    = 2;
  localparam int          ST_HIZ_BIT      = 3;
  localparam int          ST_EST_LSB      = 16;
  // reset values
  localparam logic [3:0]  GAIN_RST        = 4'h0;      // 0 db, widest range
  localparam logic [3:0]  TC_RST          = 4'h0;
  // code limits
  localparam logic [3:0]  GAIN_MAX_CODE   = 4'hC;      // 6 db in 0.5 db steps
  localparam logic [3:0]  TC_MAX_CODE     = 4'hB;      // 1100..1111 reserved
  localparam int          TC_BASE_LOG2    = 18;        // code 0 = 256k samples
  localparam int          OFS_LIMIT_LSB   = 81;        // 10 mv of a 2 vpp, 14-bit span
  // overdrive clamp codes
  localparam logic [13:0] OB_POS_CODE     = 14'h3FFF;
  localparam logic [13:0] TC_POS_CODE     = 14'h1FFF;
  localparam logic [13:0] OB_NEG_CODE     = 14'h0000;
  localparam logic [13:0] TC_NEG_CODE     = 14'h2000;
  localparam logic [13:0] OB_FLIP         = 14'h2000;  // offset binary = twos ^ msb
  // timing
  localparam int          CLK_PERIOD_NS   = 5;         // mclk 200 mhz
  localparam int          GPD_WAKE_NS     = 25000;
  localparam int          STBY_WAKE_NS    = 300;
  localparam int          OBUF_WAKE_NS    = 40;
  localparam int          LOWPWR_NS       = 1000;      // one sample per us
  localparam int          GPD_WAKE_CYC    = (GPD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STBY_WAKE_CYC   = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OBUF_WAKE_CYC   = (OBUF_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LOWPWR_CYC      = (LOWPWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // gain factors in q12, 2^(g/12) for g = 0..12 half-db steps
  localparam logic [14:0] GAIN_Q12 [13] = '{15'h1000, 15'h10F4, 15'h11F6, 15'h1307,
                                            15'h1429, 15'h155C, 15'h16A1, 15'h17F9,
                                            15'h1966, 15'h1AE9, 15'h1C82, 15'h1E34,
                                            15'h2000};

  // control register contents
  // packed to match the bus image bit for bit, so a cast moves the whole word
  typedef struct packed {
    logic       twos;               // bit 16
    logic       output_style_sel;   // bit 15
    logic       output_drive_off;   // bit 14
    logic       standby;            // bit 13
    logic       full_power_down;    // bit 12
    logic [3:0] tc;                 // bits 11..8
    logic [2:0] spare;              // bits 7..5, always read zero
    logic       ofs_en;             // bit 4
    logic [3:0] gain;               // bits 3..0
  } adbc_ctrl_s;
endpackage

// =====================================================================
// output formatter: ddr pairs or parallel pins with a forwarded clock
module adbc_ddr_out import adbc_pkg::*; #(
  parameter int DATA_W = 14
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              rise_stb,   // sample clock rose
  input  wire logic              fall_stb,   // sample clock fell
  input  wire logic [DATA_W-1:0] word,       // finished sample word
  input  wire logic              par_mode,   // 1 = one pin per bit
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_clk
);
  localparam int PAIRS = DATA_W / 2;
  logic [DATA_W-1:0] hold_q;   // word held for the falling half

  // capture the word once per sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (rise_stb) begin
      hold_q <= word;
    end
  end

  // forwarded clock follows the sample clock, so data stays in step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_clk <= 1'b0;
    end else if (rise_stb) begin
      out_clk <= 1'b1;
    end else if (fall_stb) begin
      out_clk <= 1'b0;
    end
  end

  // one generate iteration per pin
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_pin
      if (i < PAIRS) begin : g_pair
        // pair pins: split so no select ever reaches past the word
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            out_data[i] <= 1'b0;
          end else if (par_mode) begin
            if (rise_stb) begin
              out_data[i] <= word[i];
            end
          end else if (rise_stb) begin
            out_data[i] <= word[2*i+1];              // odd bit on rising edge
          end else if (fall_stb) begin
            out_data[i] <= hold_q[2*i];              // even bit on falling edge
          end
        end
      end else begin : g_upper
        // upper pins carry data only in parallel mode
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            out_data[i] <= 1'b0;
          end else if (par_mode) begin
            if (rise_stb) begin
              out_data[i] <= word[i];
            end
          end else begin
            out_data[i] <= 1'b0;                     // unused pins in pair mode
          end
        end
      end
    end
  endgenerate

  // pair 0 carries bit 1 after a rise and bit 0 after a fall
  a_ddr_odd_rise: assert property (@(posedge clk) disable iff (!rst_n)
    (rise_stb && !par_mode) |=> (out_clk && out_data[0] == $past(word[1])))
    else $error("odd bit not launched with rising clock");
  a_ddr_even_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_stb && !rise_stb && !par_mode) |=> (!out_clk && out_data[0] == hold_q[0]))
    else $error("even bit not launched with falling clock");
endmodule

`default_nettype wire

/* adbc_rx_model.sv */
`default_nettype none

// =====================================================================
// receiver model: rebuilds words from the ddr pairs or parallel pins
module adbc_rx_model import adbc_pkg::*; #(
  parameter int DATA_W = 14
) (
  // clock
  input  wire logic              clk,
  // output pins of the converter
  input  wire logic              par_mode,
  input  wire logic [DATA_W-1:0] pins,
  input  wire logic              oclk,
  // rebuilt word, got is a one-cycle strobe
  output logic      [13:0]       word,
  output logic                   got
);
  logic        oclk_q;  // output clock at the last edge
  logic [13:0] odd_q;   // odd bits caught at the rise
  initial got = 1'h0;
  // sample on both output clock edges, so neither half of a pair is lost
  always @(posedge clk) begin
    oclk_q <= oclk;
    got <= 1'h0;
    if (oclk && !oclk_q) begin
      for (int i = 0; i < 7; i++) odd_q[2*i+1] <= pins[i];
      if (par_mode) begin
        word <= pins[13:0];
        got <= 1'h1;
      end
    end else if (!oclk && oclk_q && !par_mode) begin
      for (int i = 0; i < 7; i++) begin
        word[2*i] <= pins[i];
        word[2*i+1] <= odd_q[2*i+1];
      end
      got <= 1'h1;
    end
  end
endmodule

`default_nettype wire

/* tb_top.sv */
`default_nettype none

// =====================================================================
// bench: table of sample cases, then power and register cases
module tb_top import adbc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [13:0] raw;
    logic [31:0] ctl;
    logic        op;
    logic        on;
    logic [13:0] exp;
  } adbc_row_s;
  logic MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, SAMPLE_CLK = 0, OVR_POS = 0, OVR_NEG = 0, e;
  logic PAR_CFG_MODE = 0, SERIAL_DATA_PIN = 0, FORMAT_STRAP_PIN = 0, par = 0;
  logic [13:0] RAW_DATA = 14'h0, DATA_OUT, rx_word;
  logic CONV_PD, REF_PD, LOW_POWER, OUTPUT_CLOCK_POS, OUT_EN_N, DATA_VALID;
  logic rx_got, sc_run = 1;
  int fail_count = 0, samples_checked = 0, n;
  // cases: twos input, gain 0 or 12 (exact x2), both formats, overdrive
  adbc_row_s rows [10] = '{
    '{14'h0123, 32'h0, 1'h0, 1'h0, 14'h2123}, '{14'h0123, 32'h10000, 1'h0, 1'h0, 14'h0123},
    '{14'h3F00, 32'h1000C, 1'h0, 1'h0, 14'h3E00}, '{14'h1500, 32'h1000C, 1'h0, 1'h0, 14'h1FFF},
    '{14'h0010, 32'hC, 1'h0, 1'h0, 14'h2020}, '{14'h0, 32'h0, 1'h1, 1'h0, 14'h3FFF},
    '{14'h0, 32'h10000, 1'h1, 1'h0, 14'h1FFF}, '{14'h0, 32'h0, 1'h0, 1'h1, 14'h0000},
    '{14'h0, 32'h10000, 1'h0, 1'h1, 14'h2000}, '{14'h0ABC, 32'h8000, 1'h0, 1'h0, 14'h2ABC}};
  always #2.5 MCLK = ~MCLK;
  // link clock, 125 ns, off the mclk grid; stands still when sc_run is low
  initial begin
    #1.1;
    forever #62.5 SAMPLE_CLK = sc_run ? ~SAMPLE_CLK : SAMPLE_CLK;
  end
  adbc_top #(.DATA_W(14), .GPD_WAKE(50)) i_adbc_top (.MCLK(MCLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_CLK(SAMPLE_CLK),
    .RAW_DATA(RAW_DATA), .OVR_POS(OVR_POS), .OVR_NEG(OVR_NEG), .PAR_CFG_MODE(PAR_CFG_MODE),
    .SERIAL_DATA_PIN(SERIAL_DATA_PIN), .FORMAT_STRAP_PIN(FORMAT_STRAP_PIN),
    .CONV_PD(CONV_PD), .REF_PD(REF_PD), .LOW_POWER(LOW_POWER), .DATA_OUT(DATA_OUT),
    .OUTPUT_CLOCK_POS(OUTPUT_CLOCK_POS), .OUT_EN_N(OUT_EN_N), .DATA_VALID(DATA_VALID));
  adbc_rx_model #(.DATA_W(14)) i_adbc_rx_model (.clk(MCLK), .par_mode(par),
    .pins(DATA_OUT), .oclk(OUTPUT_CLOCK_POS), .word(rx_word), .got(rx_got));
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
  endtask
  // one apb transfer: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin @(posedge MCLK); end while (PREADY !== 1'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_word;
    n = 0;
    do begin @(posedge MCLK); n++; end while (rx_got !== 1'h1 && n < 200);
    chk("word_seen", n < 200, 1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog: the whole run needs well under 80k cycles
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  initial begin
    cyc(6);
    RST_N <= 1'h1;
    foreach (rows[k]) begin
      par <= rows[k].ctl[15];
      apb(1, CTRL_OFS, rows[k].ctl);
      RAW_DATA <= rows[k].raw;
      OVR_POS <= rows[k].op;
      OVR_NEG <= rows[k].on;
      cyc(80); // old words flush out first
      wait_word();
      chk("word", rx_word, rows[k].exp);
    end
    // second reset in mid-run: control word returns to zero
    RST_N <= 1'h0;
    cyc(3);
    RST_N <= 1'h1;
    apb(0, CTRL_OFS, 0);
    chk("ctrl_rst", r, 0);
    apb(1, CTRL_OFS, 32'hC02);
    apb(0, CTRL_OFS, 0);
    chk("tc_reserved", r, 32'h2);
    apb(1, CTRL_OFS, 32'hB00);
    apb(0, CTRL_OFS, 0);
    chk("tc_max", r, 32'hB00);
    apb(1, 12'h008, 32'h1000);
    chk("slverr", e, 1);
    apb(0, CTRL_OFS, 0);
    chk("unmapped_wr", r, 32'hB00);
    apb(1, CTRL_OFS, 32'hB0D);
    apb(0, CTRL_OFS, 0);
    chk("gain_max", r, 32'hB00);
    apb(1, CTRL_OFS, 32'h110);
    apb(1, CTRL_OFS, 32'h010);
    apb(0, STAT_OFS, 0);
    chk("lock", r[ST_LOCK_BIT], 1);
    apb(1, CTRL_OFS, 32'h7000);
    cyc(2);
    chk("gpd_pins", {REF_PD, CONV_PD, OUT_EN_N, DATA_VALID}, 4'hE);
    apb(1, CTRL_OFS, 0);
    n = 0;
    while (DATA_VALID !== 1'h1 && n < 300) begin @(posedge MCLK); n++; end
    chk("gpd_wake", n >= 45 && n <= 55, 1);
    apb(1, CTRL_OFS, 32'h2000);
    cyc(2);
    chk("stby_pins", {REF_PD, CONV_PD, OUT_EN_N}, 3'h2);
    apb(1, CTRL_OFS, 0);
    n = 0;
    while (DATA_VALID !== 1'h1 && n < 300) begin @(posedge MCLK); n++; end
    chk("stby_wake", n >= 55 && n <= 65, 1);
    apb(1, CTRL_OFS, 32'h4000);
    cyc(2);
    chk("drv_off", OUT_EN_N, 1);
    apb(1, CTRL_OFS, 0);
    n = 0;
    while (OUT_EN_N !== 1'h0 && n < 300) begin @(posedge MCLK); n++; end
    chk("drv_wake", n >= 6 && n <= 10, 1);
    PAR_CFG_MODE <= 1'h1;
    SERIAL_DATA_PIN <= 1'h1;
    cyc(6);
    chk("pin_gpd", REF_PD, 1);
    SERIAL_DATA_PIN <= 1'h0;
    FORMAT_STRAP_PIN <= 1'h1;
    par <= 1'h1;
    RAW_DATA <= 14'h0123;
    cyc(150);
    wait_word();
    chk("strap_word", rx_word, 14'h0123);
    PAR_CFG_MODE <= 1'h0;
    sc_run = 0;
    cyc(260);
    chk("low_power", LOW_POWER, 1);
    apb(0, STAT_OFS, 0);
    chk("stat_lowpwr", r[ST_LOWPWR_BIT], 1);
    sc_run = 1;
    cyc(100);
    chk("low_power_off", LOW_POWER, 0);
    end_sim();
  end
endmodule

`default_nettype wire
